// >>> inc/can_csr_consts.vh
// Constants of the CAN control and status register block.
// Included by the block's design file; holds definitions only.
`ifndef CAN_CSR_CONSTS_VH
`define CAN_CSR_CONSTS_VH

// Byte offsets on the APB register bus
`define OFS_MODE_CTRL 12'h000
`define OFS_CMP_LEN 12'h004
`define OFS_INT_SRC 12'h008
`define OFS_FIFO_CFG 12'h00C
`define OFS_FIFO_PTR 12'h010
`define OFS_FLAGS 12'h014
`define OFS_BUF_CLR 12'h018

// Mode control fields
`define BIT_HALT_IDLE 13
`define BIT_ABORT_ALL 12
`define REQ_HI 10
`define REQ_LO 8
`define CUR_HI 7
`define CUR_LO 5
`define BIT_CAPTURE 3
`define BIT_WINDOW 0

// Operating mode codes
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN 3'h3
`define MODE_CONFIG 3'h4
`define MODE_RSVD_A 3'h5
`define MODE_RSVD_B 3'h6
`define MODE_LISTEN_ALL 3'h7
`define MODE_RESET 3'h4

// Compare length
`define CMP_LEN_MAX 5'h11

// Interrupt source codes
`define INTERRUPT_SOURCE_CODE_NONE 7'h40
`define INTERRUPT_SOURCE_CODE_ERROR 7'h41
`define INTERRUPT_SOURCE_CODE_WAKE 7'h42
`define INTERRUPT_SOURCE_CODE_OVERFLOW 7'h43
`define INTERRUPT_SOURCE_CODE_FIFO 7'h44
`define MATCHED_FILTER_NUMBER_LO 8

// FIFO configuration and pointer fields
`define DMA_BUFFER_COUNT_HI 15
`define DMA_BUFFER_COUNT_LO 13
`define DMA_BUFFER_COUNT_RSVD 3'h7
`define FSA_HI 4
`define WPTR_LO 8

// Flag register bits
`define BIT_TX_BUS_OFF 13
`define BIT_INVALID 7
`define BIT_WAKEUP 6
`define BIT_ERROR 5
`define BIT_FIFO_FULL 3
`define BIT_OVERFLOW 2
`define BIT_RX_BUF 1
`define BIT_TX_BUF 0
`define FLAG_MASK 8'hEF

`endif

// >>> rtl/can_control_status_regs.v
// Control and status registers of a CAN controller, reached over APB.
// Assumes the protocol engine and message buffering run on sys_clk and
// deliver one-cycle event pulses and level states from that same clock.
//
// Notes on behaviour
// - Requested mode field selects normal, disable, loopback, listen, config, listen-all.
// - Current mode field reports the mode in effect; reads configuration after reset.
// - Abort-all bit aborts every pending transmission; hardware clears it afterwards.
// - Halt-in-idle bit stops the controller while the device idles.
// - Capture enable makes each received message produce a capture event.
// - Window select chooses filter registers when 1, buffer registers when 0.
// - Compare-length field gives leading data bits compared; 10010 upward invalid.
// - Matched filter number reports the accepting filter, 0 to 31.
// - Interrupt code reports none, error, wake-up, overflow, FIFO almost full.
// - Buffer interrupts report the buffer index as interrupt code.
// - DMA buffer count code selects 4 to 32 buffers; 111 reserved.
// - FIFO start field gives the first buffer of the receive FIFO.
// - Read-only pointer shows the buffer the FIFO writes next.
// - Read-only pointer shows the next FIFO buffer software should read.
// - Status bits show tx bus-off, tx error-passive, rx error-passive.
// - Warning bits show tx warning, rx warning, and either of them.
// - Error flag is set by any error-state source in the upper byte.
// - Invalid-message flag set by hardware; software may only clear it.
// - Wake-up flag set on bus activity; resets to 0; clear-only.
// - FIFO almost-full flag set by hardware; clear-only.
// - Receive overflow flag set when a message cannot be stored; clear-only.
// - Receive-buffer and transmit-buffer flags set by hardware; clear-only.
// - Current mode follows a new request only after an idle bus.
// - Disable during the initial idle wait aborts the pending transmission.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "can_csr_consts.vh"

module can_control_status_regs #(
  parameter BUF_IDX_W = 4,
  parameter NUM_BUF_IRQ = 16
) (
  input wire sys_clk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Protocol engine states and events
  input wire bus_idle_seen,
  input wire tx_idle_wait,
  input wire all_tx_aborted,
  input wire device_idle,
  input wire [4:0] cmp_len_in,
  input wire rx_msg_stored,
  input wire rx_to_fifo,
  input wire [4:0] rx_filter_hit,
  input wire [BUF_IDX_W-1:0] rx_buf_index,
  input wire tx_done,
  input wire [2:0] tx_buf_index,
  input wire fifo_read_done,
  input wire invalid_msg,
  input wire wake_activity,
  input wire fifo_almost_full,
  input wire rx_overflow,
  input wire tx_bus_off,
  input wire tx_error_passive,
  input wire rx_error_passive,
  input wire tx_warning,
  input wire rx_warning,
  // Controls towards the engine
  output reg [2:0] current_mode,
  output reg abort_all_tx,
  output reg abort_pending_tx,
  output reg module_halted,
  output reg capture_event,
  output reg register_window_select,
  output reg [4:0] data_compare_length,
  output reg compare_length_invalid
);

  // Number of buffers held in DMA memory for a count code
  function [5:0] buffer_total;
    input [2:0] code;
    begin
      case (code)
        3'h0: buffer_total = 6'h04;
        3'h1: buffer_total = 6'h06;
        3'h2: buffer_total = 6'h08;
        3'h3: buffer_total = 6'h0C;
        3'h4: buffer_total = 6'h10;
        3'h5: buffer_total = 6'h18;
        default: buffer_total = 6'h20;
      endcase
    end
  endfunction

  // Next FIFO buffer, wrapping from the last buffer back to the start
  function [5:0] fifo_next;
    input [5:0] ptr;
    input [4:0] start;
    input [2:0] code;
    begin
      if (ptr + 6'h01 >= buffer_total(code))
        fifo_next = {1'b0, start};
      else
        fifo_next = ptr + 6'h01;
    end
  endfunction

  // One-hot select of the writable register at an address
  function [3:0] write_target;
    input [11:0] addr;
    begin
      case (addr)
        `OFS_MODE_CTRL: write_target = 4'h1;
        `OFS_FIFO_CFG: write_target = 4'h2;
        `OFS_FLAGS: write_target = 4'h4;
        `OFS_BUF_CLR: write_target = 4'h8;
        default: write_target = 4'h0;
      endcase
    end
  endfunction

  reg [2:0] req_mode_q;
  reg halt_idle_q;
  reg capture_en_q;
  reg [2:0] dma_code_q;
  reg [4:0] fifo_start_q;
  reg [5:0] wptr_q;
  reg [5:0] rptr_q;
  reg [4:0] filter_hit_q;
  reg [5:0] err_state_q;
  reg [7:0] flags_q;
  reg [NUM_BUF_IRQ-1:0] buf_pend_q;
  reg [6:0] interrupt_source_code_q;
  reg [6:0] interrupt_source_code_d;
  reg [31:0] rdata_d;
  reg mapped_d;

  wire setup_ph;
  wire wr_acc;
  wire [3:0] wr_sel;
  wire wr_mode;
  wire wr_fcfg;
  wire wr_flags;
  wire wr_bclr;
  wire [2:0] wr_req;
  wire req_legal;
  wire mode_move;
  wire [5:0] err_state_d;
  wire err_rise;
  wire [7:0] flag_set;
  wire [7:0] flag_keep;

  // APB phases; a write lands on the access edge, where pready is high
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;

  // Write strobes of the writable registers
  assign wr_sel = write_target(paddr);
  assign wr_mode = wr_acc & wr_sel[0];
  assign wr_fcfg = wr_acc & wr_sel[1];
  assign wr_flags = wr_acc & wr_sel[2];
  assign wr_bclr = wr_acc & wr_sel[3];
  assign wr_req = pwdata[`REQ_HI:`REQ_LO];

  // Reserved codes leave the old request standing
  assign req_legal = (wr_req != `MODE_RSVD_A) && (wr_req != `MODE_RSVD_B);
  // The mode in effect moves only on an idle bus, never mid-frame
  assign mode_move = (current_mode != req_mode_q) && bus_idle_seen;

  // Error states and the rise of any of them
  assign err_state_d = {tx_bus_off, tx_error_passive, rx_error_passive,
                        tx_warning, rx_warning, tx_warning | rx_warning};
  assign err_rise = |(err_state_d & ~err_state_q);

  // Hardware set events, and the keep mask of a software write
  assign flag_set = {invalid_msg, wake_activity, err_rise, 1'b0,
                     fifo_almost_full, rx_overflow, rx_msg_stored, tx_done};
  assign flag_keep = wr_flags ? pwdata[7:0] : 8'hFF;

  // Mode request and mode in effect
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_mode_q <= `MODE_RESET;
      current_mode <= `MODE_RESET;
      abort_pending_tx <= 1'b0;
    end else begin
      if (wr_mode && req_legal)
        req_mode_q <= wr_req;
      if (mode_move)
        current_mode <= req_mode_q;
      abort_pending_tx <= wr_mode && wr_req == `MODE_DISABLE && tx_idle_wait;
    end
  end

  // Abort-all request; a software set beats the engine's done
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      abort_all_tx <= 1'b0;
    end else if (wr_mode && pwdata[`BIT_ABORT_ALL]) begin
      abort_all_tx <= 1'b1;
    end else if (all_tx_aborted) begin
      abort_all_tx <= 1'b0;
    end
  end

  // Software control bits of the mode register
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      halt_idle_q <= 1'b0;
      capture_en_q <= 1'b0;
      register_window_select <= 1'b0;
    end else if (wr_mode) begin
      halt_idle_q <= pwdata[`BIT_HALT_IDLE];
      capture_en_q <= pwdata[`BIT_CAPTURE];
      register_window_select <= pwdata[`BIT_WINDOW];
    end
  end

  // Halt and capture outputs, one cycle behind their causes
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      module_halted <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      module_halted <= halt_idle_q & device_idle;
      capture_event <= capture_en_q & rx_msg_stored;
    end
  end

  // Compare length from the filter engine
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_compare_length <= 5'h00;
      compare_length_invalid <= 1'b0;
    end else begin
      data_compare_length <= cmp_len_in;
      compare_length_invalid <= cmp_len_in > `CMP_LEN_MAX;
    end
  end

  // FIFO configuration and pointers
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dma_code_q <= 3'h0;
      fifo_start_q <= 5'h00;
      wptr_q <= 6'h00;
      rptr_q <= 6'h00;
    end else if (wr_fcfg) begin
      if (pwdata[`DMA_BUFFER_COUNT_HI:`DMA_BUFFER_COUNT_LO] != `DMA_BUFFER_COUNT_RSVD)
        dma_code_q <= pwdata[`DMA_BUFFER_COUNT_HI:`DMA_BUFFER_COUNT_LO];
      fifo_start_q <= pwdata[`FSA_HI:0];
      wptr_q <= {1'b0, pwdata[`FSA_HI:0]};
      rptr_q <= {1'b0, pwdata[`FSA_HI:0]};
    end else begin
      if (rx_to_fifo)
        wptr_q <= fifo_next(wptr_q, fifo_start_q, dma_code_q);
      if (fifo_read_done)
        rptr_q <= fifo_next(rptr_q, fifo_start_q, dma_code_q);
    end
  end

  // Registered error states and the filter of the last stored message
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      err_state_q <= 6'h00;
      filter_hit_q <= 5'h00;
    end else begin
      err_state_q <= err_state_d;
      if (rx_msg_stored)
        filter_hit_q <= rx_filter_hit;
    end
  end

  // Clear-only flags; a hardware set in the same cycle beats the clear
  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      flags_q <= 8'h00;
    else
      flags_q <= ((flags_q & flag_keep) | flag_set) & `FLAG_MASK;
  end

  // Per-buffer pending bits; writing 1 to the clear register drops one
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUF_IRQ; gi = gi + 1) begin : g_pend
      wire set_rx = rx_msg_stored && rx_buf_index == gi;
      wire set_tx = tx_done && tx_buf_index == gi;
      always @(posedge sys_clk or posedge reset) begin
        if (reset)
          buf_pend_q[gi] <= 1'b0;
        else if (set_rx || set_tx)
          buf_pend_q[gi] <= 1'b1;
        else if (wr_bclr && pwdata[gi])
          buf_pend_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // Interrupt code by fixed priority: module events, then lowest buffer
  integer bi;
  always @* begin
    interrupt_source_code_d = `INTERRUPT_SOURCE_CODE_NONE;
    for (bi = NUM_BUF_IRQ - 1; bi >= 0; bi = bi - 1) begin
      if (buf_pend_q[bi])
        interrupt_source_code_d = bi[6:0];
    end
    if (flags_q[`BIT_FIFO_FULL])
      interrupt_source_code_d = `INTERRUPT_SOURCE_CODE_FIFO;
    if (flags_q[`BIT_OVERFLOW])
      interrupt_source_code_d = `INTERRUPT_SOURCE_CODE_OVERFLOW;
    if (flags_q[`BIT_WAKEUP])
      interrupt_source_code_d = `INTERRUPT_SOURCE_CODE_WAKE;
    if (flags_q[`BIT_ERROR])
      interrupt_source_code_d = `INTERRUPT_SOURCE_CODE_ERROR;
  end

  // Registered code, so a read sees a settled value
  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      interrupt_source_code_q <= `INTERRUPT_SOURCE_CODE_NONE;
    else
      interrupt_source_code_q <= interrupt_source_code_d;
  end

  // Read data mux
  always @* begin
    rdata_d = 32'h00000000;
    mapped_d = 1'b1;
    case (paddr)
      `OFS_MODE_CTRL: begin
        rdata_d[`BIT_HALT_IDLE] = halt_idle_q;
        rdata_d[`BIT_ABORT_ALL] = abort_all_tx;
        rdata_d[`REQ_HI:`REQ_LO] = req_mode_q;
        rdata_d[`CUR_HI:`CUR_LO] = current_mode;
        rdata_d[`BIT_CAPTURE] = capture_en_q;
        rdata_d[`BIT_WINDOW] = register_window_select;
      end
      `OFS_CMP_LEN: rdata_d[4:0] = data_compare_length;
      `OFS_INT_SRC: begin
        rdata_d[`MATCHED_FILTER_NUMBER_LO+4:`MATCHED_FILTER_NUMBER_LO] = filter_hit_q;
        rdata_d[6:0] = interrupt_source_code_q;
      end
      `OFS_FIFO_CFG: begin
        rdata_d[`DMA_BUFFER_COUNT_HI:`DMA_BUFFER_COUNT_LO] = dma_code_q;
        rdata_d[`FSA_HI:0] = fifo_start_q;
      end
      `OFS_FIFO_PTR: begin
        rdata_d[`WPTR_LO+5:`WPTR_LO] = wptr_q;
        rdata_d[5:0] = rptr_q;
      end
      `OFS_FLAGS: begin
        rdata_d[`BIT_TX_BUS_OFF:8] = err_state_q;
        rdata_d[7:0] = flags_q;
      end
      `OFS_BUF_CLR: rdata_d[NUM_BUF_IRQ-1:0] = buf_pend_q;
      default: mapped_d = 1'b0;
    endcase
  end

  // APB answer: registered in setup, valid through the access cycle
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped_d;
      if (setup_ph)
        prdata <= pwrite ? 32'h00000000 : rdata_d;
    end
  end

endmodule

// >>> tb/can_csr_sva.sv
// Port assertions for the CAN register block.
// Bound into the block by tb; one clock domain.
`timescale 1ns/1ps
module can_csr_sva (
  input wire sys_clk,
  input wire reset,
  input wire bus_idle_seen,
  input wire [2:0] current_mode,
  input wire abort_all_tx,
  input wire all_tx_aborted,
  input wire device_idle,
  input wire module_halted,
  input wire rx_msg_stored,
  input wire capture_event,
  input wire [4:0] cmp_len_in,
  input wire [4:0] data_compare_length,
  input wire compare_length_invalid,
  input wire tx_idle_wait,
  input wire abort_pending_tx
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  AST_MODE_HOLD:
    assert property (!bus_idle_seen |=> $stable(current_mode)) else $error("mode moved");
  AST_MODE_CODE:
    assert property (current_mode != 3'h5 && current_mode != 3'h6) else $error("bad mode");
  AST_ABT_HOLD:
    assert property (abort_all_tx && !all_tx_aborted |=> abort_all_tx) else $error("abort");
  AST_HALT:
    assert property (module_halted |-> $past(device_idle)) else $error("halt");
  AST_CAPT:
    assert property (capture_event |-> $past(rx_msg_stored)) else $error("capture");
  AST_CMP_INV:
    assert property (##1 compare_length_invalid == ($past(cmp_len_in) > 5'h11))
      else $error("invalid");
  AST_CMP_LEN:
    assert property (##1 data_compare_length == $past(cmp_len_in)) else $error("length");
  AST_ABT_TX:
    assert property (abort_pending_tx |-> $past(tx_idle_wait) ##1 !abort_pending_tx)
      else $error("tx abort");
  cover property (bus_idle_seen ##1 current_mode == 3'h7);
  cover property (abort_pending_tx);
  cover property (capture_event);
endmodule

// >>> tb/can_bus_peer.sv
// Far side: idle-bus detector and slow abort engine.
// One bit time lasts BIT_CYC cycles of sys_clk.
`timescale 1ns/1ps
module can_bus_peer #(
  parameter int BIT_CYC = 2,
  parameter int ABT_DLY = 20
) (
  input wire sys_clk,
  input wire reset,
  input wire idle_req,
  input wire abort_all_tx,
  output wire bus_idle_seen,
  output wire all_tx_aborted
);
  logic [7:0] idle_q, abt_q;
  assign bus_idle_seen = idle_q == 8'(11 * BIT_CYC);
  assign all_tx_aborted = abt_q == 8'(ABT_DLY);
  // Eleven recessive bits, then a delayed abort
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      idle_q <= 8'h00;
      abt_q <= 8'h00;
    end else begin
      idle_q <= idle_req ? 8'h01 : (idle_q != 8'h00 && !bus_idle_seen) ? idle_q + 8'h01 : 8'h00;
      abt_q <= (abort_all_tx && !all_tx_aborted) ? abt_q + 8'h01 : 8'h00;
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the CAN register block.
// Assumes 200 MHz sys_clk and an APB slave.
`timescale 1ns/1ps
module tb;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er, ti, di, iq, bi, ta;
  logic am, ap, ha, ce, ws, ci;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pe;
  logic [4:0] es, cl, dl;
  logic [2:0] cm;
  logic [1:0] fp;
  int n_mismatch, total_checks, apc;
  can_control_status_regs can_control_status_regs_i (.sys_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_idle_seen(bi),
    .tx_idle_wait(ti), .all_tx_aborted(ta), .device_idle(di), .cmp_len_in(cl),
    .rx_msg_stored(pe[4]), .rx_to_fifo(fp[0]), .rx_filter_hit(5'h0F), .rx_buf_index(4'h9),
    .tx_done(pe[5]), .tx_buf_index(3'h3), .fifo_read_done(fp[1]), .invalid_msg(pe[0]),
    .wake_activity(pe[1]), .fifo_almost_full(pe[2]), .rx_overflow(pe[3]),
    .tx_bus_off(es[4]), .tx_error_passive(es[3]), .rx_error_passive(es[2]),
    .tx_warning(es[1]), .rx_warning(es[0]), .current_mode(cm), .abort_all_tx(am),
    .abort_pending_tx(ap), .module_halted(ha), .capture_event(ce),
    .register_window_select(ws), .data_compare_length(dl), .compare_length_invalid(ci));
  can_bus_peer can_bus_peer_i (.sys_clk, .reset, .idle_req(iq), .abort_all_tx(am),
    .bus_idle_seen(bi), .all_tx_aborted(ta));
  // Clock
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Counts early transmit aborts
  always @(posedge sys_clk) apc += (ap === 1'h1);
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      results;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task ev(input logic [5:0] v, input logic [1:0] f);
    @(posedge sys_clk);
    {pe, fp} <= {v, f};
    @(posedge sys_clk);
    {pe, fp} <= 8'h00;
  endtask
  task t_modes;
    logic [2:0] ml [6];
    logic [2:0] c, p;
    ml = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
    p = 3'h4;
    rdc(12'h000, 32'h480);
    ti <= 1'h1;
    foreach (ml[i]) begin
      c = (ml[i] == 3'h5) ? p : ml[i];
      apb(1'h1, 12'h000, {21'h0, ml[i], 8'h00});
      rdc(12'h000, {21'h0, c, p, 5'h00});
      iq <= 1'h1;
      @(posedge sys_clk);
      iq <= 1'h0;
      repeat (26) @(posedge sys_clk);
      rdc(12'h000, {21'h0, c, c, 5'h00});
      chk(cm, c);
      p = c;
    end
    ti <= 1'h0;
    chk(apc, 32'h1);
  endtask
  task t_abort;
    int k;
    apb(1'h1, 12'h000, 32'h1700);
    rdc(12'h000, 32'h17E0);
    for (k = 0; am !== 1'h0 && k < 60; k++) @(posedge sys_clk);
    chk(k < 60, 32'h1);
    if (k >= 60) results;
    rdc(12'h000, 32'h07E0);
  endtask
  task t_ctrl;
    apb(1'h1, 12'h000, 32'h2709);
    di <= 1'h1;
    ev(6'h10, 2'h0);
    @(negedge sys_clk);
    chk({ha, ce, ws}, 32'h7);
    rdc(12'h000, 32'h27E9);
    di <= 1'h0;
    apb(1'h1, 12'h000, 32'h0700);
    ev(6'h10, 2'h0);
    @(negedge sys_clk);
    chk({ha, ce, ws}, 32'h0);
  endtask
  task t_flags;
    logic [7:0] wv [3];
    wv = '{8'hDF, 8'h9F, 8'h9B};
    es <= 5'h12;
    ev(6'h3F, 2'h0);
    rdc(12'h014, 32'h25EF);
    rdc(12'h008, 32'h0F41);
    foreach (wv[i]) begin
      apb(1'h1, 12'h014, {24'h0, wv[i]});
      rdc(12'h008, 32'h0F42 + i);
    end
    apb(1'h1, 12'h014, 32'h0);
    rdc(12'h008, 32'h0F03);
    apb(1'h1, 12'h018, 32'h8);
    rdc(12'h008, 32'h0F09);
    apb(1'h1, 12'h018, 32'h200);
    apb(1'h1, 12'h014, 32'hFFFF);
    rdc(12'h014, 32'h2500);
    rdc(12'h008, 32'h0F40);
  endtask
  task t_fifo;
    apb(1'h1, 12'h00C, 32'h2);
    ev(6'h00, 2'h1);
    rdc(12'h010, 32'h0302);
    ev(6'h00, 2'h1);
    ev(6'h00, 2'h2);
    rdc(12'h010, 32'h0203);
    apb(1'h1, 12'h00C, 32'hE005);
    rdc(12'h00C, 32'h5);
    apb(1'h0, 12'h040, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    cl <= 5'h12;
    rdc(12'h004, 32'h12);
    chk(ci, 32'h1);
    chk(dl, 32'h12);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ti, di, iq, pe, es, cl, fp} = '0;
    reset = 1'h1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'h0;
    t_modes;
    t_abort;
    t_ctrl;
    t_flags;
    t_fifo;
    results;
  end
endmodule
bind can_control_status_regs can_csr_sva can_csr_sva_i (.sys_clk, .reset, .bus_idle_seen,
  .current_mode, .abort_all_tx, .all_tx_aborted, .device_idle, .module_halted,
  .rx_msg_stored, .capture_event, .cmp_len_in, .data_compare_length,
  .compare_length_invalid, .tx_idle_wait, .abort_pending_tx);
